// ### design/afc_adc_map.vh
/*
 * register offsets, field positions, codes and reset values for the
 * converter control and result block.
 * assumes an 8-bit register port with byte-wide index addressing.
 */
`ifndef AFC_ADC_MAP_VH
`define AFC_ADC_MAP_VH

// register indexes on the plain register port
`define AFC_ADDR_W          3
`define AFC_REG_CTRL0       3'h0
`define AFC_REG_CTRL1       3'h1
`define AFC_REG_RES_HI      3'h2
`define AFC_REG_RES_LO      3'h3
`define AFC_REG_INT_STAT    3'h4
`define AFC_REG_INT_MASK    3'h5

// control zero fields
`define AFC_CHAN_HI         6
`define AFC_CHAN_LO         2
`define AFC_GO_BIT          1
`define AFC_ON_BIT          0

// control one fields
`define AFC_JUST_BIT        7
`define AFC_DIV_HI          6
`define AFC_DIV_LO          4
`define AFC_PREF_HI         1
`define AFC_PREF_LO         0
`define AFC_CTRL1_MASK      8'hf3

// channel codes
`define AFC_CHAN_REFBUF     5'h1f
`define AFC_CHAN_RSVD       5'h1e
`define AFC_CHAN_RSVD_B     5'h0e

// divider codes
`define AFC_DIV_2           3'h0
`define AFC_DIV_8           3'h1
`define AFC_DIV_32          3'h2
`define AFC_DIV_4           3'h4
`define AFC_DIV_16          3'h5
`define AFC_DIV_64          3'h6

// conversion period length in clock cycles per divider code
`define AFC_TAD_DIV2        16'h0002
`define AFC_TAD_DIV8        16'h0008
`define AFC_TAD_DIV32       16'h0020
`define AFC_TAD_DIV4        16'h0004
`define AFC_TAD_DIV16       16'h0010
`define AFC_TAD_DIV64       16'h0040

// reset values
`define AFC_CTRL0_RST       8'h00
`define AFC_CTRL1_RST       8'h00
`define AFC_BYTE_ZERO       8'h00

// interrupt status bit
`define AFC_INT_DONE_BIT    0

// conversion length in conversion clock periods
`define AFC_CONV_TADS       11
// internal rc clock period in ns, and the 4 ns ref_clk period in ns
`define AFC_FRC_NS          2000
`define AFC_CLK_NS          4

`endif

// ### design/afc_result_pack.v
/*
 * packs a 10-bit conversion result into the high and low result bytes.
 * assumes the caller loads both bytes in the same cycle.
 */
`timescale 1ns/1ps
module afc_result_pack (
   input  wire [9:0] conversion_result,   // raw converter result
   input  wire       result_justify_select, // 1 right, 0 left
   output reg  [7:0] pack_high,           // high byte image
   output reg  [7:0] pack_low             // low byte image
);

   // justification layout
   always @* begin
      if (result_justify_select) begin
         pack_high = {6'h00, conversion_result[9:8]};
         pack_low  = conversion_result[7:0];
      end else begin
         pack_high = conversion_result[9:2];
         pack_low  = {conversion_result[1:0], 6'h00};
      end
   end

endmodule // afc_result_pack

// ### design/afc_adc_ctrl.v
/*
 * converter control and result block: channel routing, conversion
 * sequencing, justified result bytes, register port and interrupt.
 * assumes the analog converter presents a settled 10-bit sample on
 * conv_sample while a conversion runs, and that all inputs are
 * synchronous to ref_clk.
 */
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "afc_adc_map.vh"
module afc_adc_ctrl #(
   parameter CONV_TADS = `AFC_CONV_TADS,                 // conversion periods
   parameter FRC_CYC   = `AFC_FRC_NS / `AFC_CLK_NS       // rc period in cycles
) (
   input  wire                    ref_clk,        // 250 mhz clock
   input  wire                    rst_b,          // async reset, low
   input  wire [`AFC_ADDR_W-1:0]  reg_addr,       // register index
   input  wire [7:0]              reg_wdata,      // write data
   input  wire                    reg_wr,         // write strobe
   input  wire                    reg_rd,         // read strobe
   output reg  [7:0]              reg_rdata,      // read data, next cycle
   input  wire [9:0]              conv_sample,    // converter sample
   output wire [4:0]              input_channel_select, // mux code
   output wire                    fixed_voltage_reference, // route buffer
   output wire                    channel_connect, // mux switch closed
   output wire                    converter_power_enable, // analog power
   output wire [1:0]              positive_reference_select, // ref choice
   output wire                    conv_busy,      // conversion running
   output wire                    irq             // level interrupt
);

   localparam ST_IDLE = 1'b0;   // waiting for go
   localparam ST_CONV = 1'b1;   // counting conversion periods

   reg  [7:0]  ctrl0;           // channel, go, enable
   reg  [7:0]  converter_control_one; // justify, divider, reference
   reg  [7:0]  result_high_byte; // high result byte
   reg  [7:0]  result_low_byte;  // low result byte
   reg  [7:0]  int_stat;        // sticky events
   reg  [7:0]  int_mask;        // event enables
   reg         state;           // sequencer state
   reg  [15:0] pre_cnt;         // conversion clock prescaler
   reg  [7:0]  tad_cnt;         // conversion periods done
   wire [7:0]  pack_high;       // justified high byte
   wire [7:0]  pack_low;        // justified low byte
   wire        go;              // go flag
   wire        on;              // enable flag
   wire        tad_tick;        // end of one conversion period
   wire        conv_done;       // result load this cycle
   wire        go_write;        // software sets go

   // conversion clock period in ref_clk cycles for a divider code
   function [15:0] tad_cycles;
      input [2:0] code;
      begin
         case (code)
            // clock-derived periods, one count per divided step
            `AFC_DIV_2:  tad_cycles = `AFC_TAD_DIV2;
            `AFC_DIV_8:  tad_cycles = `AFC_TAD_DIV8;
            `AFC_DIV_32: tad_cycles = `AFC_TAD_DIV32;
            `AFC_DIV_4:  tad_cycles = `AFC_TAD_DIV4;
            `AFC_DIV_16: tad_cycles = `AFC_TAD_DIV16;
            `AFC_DIV_64: tad_cycles = `AFC_TAD_DIV64;
            // internal rc clock codes
            default:     tad_cycles = FRC_CYC[15:0];
         endcase
      end
   endfunction

   // register fields; the analog side sees them directly
   assign go  = ctrl0[`AFC_GO_BIT];
   assign on  = ctrl0[`AFC_ON_BIT];
   assign input_channel_select = ctrl0[`AFC_CHAN_HI:`AFC_CHAN_LO];
   assign converter_power_enable = on;
   assign positive_reference_select =
      converter_control_one[`AFC_PREF_HI:`AFC_PREF_LO];
   assign fixed_voltage_reference = on && (input_channel_select == `AFC_CHAN_REFBUF);
   assign channel_connect = on && (input_channel_select != `AFC_CHAN_RSVD)
                            && (input_channel_select != `AFC_CHAN_RSVD_B);
   assign conv_busy = (state == ST_CONV);
   // wrap one count early so a period lasts exactly its cycle count
   assign tad_tick  = conv_busy && (pre_cnt ==
      tad_cycles(converter_control_one[`AFC_DIV_HI:`AFC_DIV_LO]) - 16'h0001);
   assign conv_done = tad_tick && (tad_cnt == CONV_TADS[7:0] - 8'h01);
   // go write decode; the enable test sits where the flag is set
   assign go_write  = reg_wr && (reg_addr == `AFC_REG_CTRL0) &&
                      reg_wdata[`AFC_GO_BIT];
   // level output, only as long as an unmasked sticky bit stands
   assign irq       = |(int_stat & int_mask);

   // justified result bytes
   afc_result_pack u_pack (
      .conversion_result     (conv_sample),
      .result_justify_select (converter_control_one[`AFC_JUST_BIT]),
      .pack_high             (pack_high),
      .pack_low              (pack_low)
   );

   // control registers; go is owned by hardware once set
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl0 <= `AFC_CTRL0_RST;
         converter_control_one <= `AFC_CTRL1_RST;
         int_mask <= `AFC_BYTE_ZERO;
      end else begin
         if (reg_wr && reg_addr == `AFC_REG_CTRL0) begin
            ctrl0[`AFC_CHAN_HI:`AFC_CHAN_LO] <= reg_wdata[`AFC_CHAN_HI:`AFC_CHAN_LO];
            ctrl0[`AFC_ON_BIT] <= reg_wdata[`AFC_ON_BIT];
         end
         if (go_write && on && reg_wdata[`AFC_ON_BIT]) begin
            ctrl0[`AFC_GO_BIT] <= 1'b1;
         end else if (conv_done || !on) begin
            ctrl0[`AFC_GO_BIT] <= 1'b0;
         end
         if (reg_wr && reg_addr == `AFC_REG_CTRL1) begin
            // unimplemented bits stay zero
            converter_control_one <= reg_wdata & `AFC_CTRL1_MASK;
         end
         if (reg_wr && reg_addr == `AFC_REG_INT_MASK) begin
            int_mask <= reg_wdata;
         end
      end
   end

   // conversion sequencer
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= ST_IDLE;
         pre_cnt <= 16'h0000;
         tad_cnt <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               pre_cnt <= 16'h0000;
               tad_cnt <= 8'h00;
               if (go && on) begin
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (!on || conv_done) begin
                  // power off aborts without a result
                  state <= ST_IDLE;
               end else if (tad_tick) begin
                  pre_cnt <= 16'h0000;
                  tad_cnt <= tad_cnt + 8'h01;
               end else begin
                  pre_cnt <= pre_cnt + 16'h0001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // result bytes: software writable, hardware load wins
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         result_high_byte <= `AFC_BYTE_ZERO;
         result_low_byte  <= `AFC_BYTE_ZERO;
      end else if (conv_done && on) begin
         result_high_byte <= pack_high;
         result_low_byte  <= pack_low;
      end else if (reg_wr) begin
         if (reg_addr == `AFC_REG_RES_HI) begin
            result_high_byte <= reg_wdata;
         end
         if (reg_addr == `AFC_REG_RES_LO) begin
            result_low_byte <= reg_wdata;
         end
      end
   end

   // sticky status: read clears, a new event in that cycle wins
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_stat <= `AFC_BYTE_ZERO;
      end else begin
         if (reg_rd && reg_addr == `AFC_REG_INT_STAT) begin
            int_stat <= `AFC_BYTE_ZERO;
         end
         if (conv_done && on) begin
            int_stat[`AFC_INT_DONE_BIT] <= 1'b1;
         end
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `AFC_BYTE_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            `AFC_REG_CTRL0:    reg_rdata <= ctrl0;
            `AFC_REG_CTRL1:    reg_rdata <= converter_control_one;
            `AFC_REG_RES_HI:   reg_rdata <= result_high_byte;
            `AFC_REG_RES_LO:   reg_rdata <= result_low_byte;
            `AFC_REG_INT_STAT: reg_rdata <= int_stat;
            `AFC_REG_INT_MASK: reg_rdata <= int_mask;
            // unmapped index
            default:           reg_rdata <= `AFC_BYTE_ZERO;
         endcase
      end else begin
         reg_rdata <= `AFC_BYTE_ZERO;
      end
   end

endmodule // afc_adc_ctrl

// ### bench/afc_adc_ctrl_assertions.sv
/*
 checker for the converter control block: routing, start and readback.
 assumes it sees only the top ports, that software touches neither the
 result bytes nor the justify bit while busy, and that an aborted
 conversion keeps its sample steady.
*/
`timescale 1ns/1ps
`include "afc_adc_map.vh"
module afc_adc_chk (
   input wire                   ref_clk,
   input wire                   rst_b,
   input wire [`AFC_ADDR_W-1:0] reg_addr,
   input wire [7:0]             reg_wdata,
   input wire                   reg_wr,
   input wire                   reg_rd,
   input wire [7:0]             reg_rdata,
   input wire [9:0]             conv_sample,
   input wire [4:0]             input_channel_select,
   input wire                   fixed_voltage_reference,
   input wire                   channel_connect,
   input wire                   converter_power_enable,
   input wire                   conv_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   reg       just;   // justify bit from the last control one write
   reg       jl;     // justify in force during the conversion
   reg [9:0] cap;    // last sample seen while busy, the loaded one
   reg       sw_hi;  // high byte last set by software
   reg       sw_lo;  // low byte last set by software
   reg [7:0] sw_hv;  // software value of the high byte
   reg [7:0] sw_lv;  // software value of the low byte
   // shadow of what the result bytes should hold
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         just <= 1'b0;
         jl   <= 1'b0;
         cap  <= 10'h000;
         sw_hi <= 1'b0;
         sw_lo <= 1'b0;
         sw_hv <= 8'h00;
         sw_lv <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == `AFC_REG_CTRL1) begin
            just <= reg_wdata[`AFC_JUST_BIT];
         end
         if (conv_busy) begin
            // a result load overrides earlier software values
            cap <= conv_sample;
            jl  <= just;
            sw_hi <= 1'b0;
            sw_lo <= 1'b0;
         end else begin
            if (reg_wr && reg_addr == `AFC_REG_RES_HI) begin
               sw_hi <= 1'b1;
               sw_hv <= reg_wdata;
            end
            if (reg_wr && reg_addr == `AFC_REG_RES_LO) begin
               sw_lo <= 1'b1;
               sw_lv <= reg_wdata;
            end
         end
      end
   end
   refbuf_route_a: assert property (fixed_voltage_reference ==
      (converter_power_enable && input_channel_select == 5'h1f))
      else $error("reference buffer routing wrong");
   no_connect_a: assert property (input_channel_select == 5'h1e |-> !channel_connect)
      else $error("reserved code connects a channel");
   res_high_a: assert property ($past(reg_rd && reg_addr == `AFC_REG_RES_HI) |->
      reg_rdata == (sw_hi ? sw_hv : jl ? {6'h00, cap[9:8]} : cap[9:2]))
      else $error("high byte layout wrong");
   res_low_a: assert property ($past(reg_rd && reg_addr == `AFC_REG_RES_LO) |->
      reg_rdata == (sw_lo ? sw_lv : jl ? cap[7:0] : {cap[1:0], 6'h00}))
      else $error("low byte layout wrong");
   go_start_a: assert property (reg_wr && reg_addr == `AFC_REG_CTRL0 &&
      reg_wdata[1:0] == 2'b11 && converter_power_enable && !conv_busy |-> ##2 conv_busy)
      else $error("go did not start a conversion");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
endmodule // afc_adc_chk
bind afc_adc_ctrl afc_adc_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .conv_sample(conv_sample), .input_channel_select(input_channel_select),
   .fixed_voltage_reference(fixed_voltage_reference), .channel_connect(channel_connect),
   .converter_power_enable(converter_power_enable), .conv_busy(conv_busy));

// ### bench/afc_adc_ctrl_tb.sv
/*
 self-checking bench for the converter control block.
 assumes a 250 mhz clock and a shortened conversion (two periods).
*/
`timescale 1ns/1ps
`include "afc_adc_map.vh"
module afc_adc_ctrl_tb;
   localparam CT = 2;          // shortened conversion length
   reg        ref_clk, rst_b;  // clock and reset
   reg        reg_wr, reg_rd;  // register strobes
   reg  [2:0] reg_addr;        // register index
   reg  [7:0] reg_wdata;       // write data
   reg  [9:0] conv_sample;     // converter sample
   wire [7:0] reg_rdata;       // read data
   wire [4:0] chan;            // channel code out
   wire [1:0] pref;            // reference choice
   wire       refbuf, conn, pwr, busy, irq;
   integer    n_fail, n_compared;
   afc_adc_ctrl #(.CONV_TADS(CT), .FRC_CYC(4)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .conv_sample(conv_sample), .input_channel_select(chan),
      .fixed_voltage_reference(refbuf), .channel_connect(conn), .converter_power_enable(pwr),
      .positive_reference_select(pref), .conv_busy(busy), .irq(irq));
   // compare and count
   task chk(input [9:0] got, input [9:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one-cycle write strobe
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   // one-cycle read, data looked at in the following cycle only
   task rd(input [2:0] a, input [7:0] exp);
      begin
         @(posedge ref_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata, exp);
      end
   endtask
   // reset values, unimplemented bits, unmapped index 7
   task t_regs;
      begin
         rd(3'h1, 8'h00);
         rd(3'h2, 8'h00);
         rd(3'h4, 8'h00);
         wr(3'h1, 8'hff);
         #1 chk(pref, 2'h3);
         rd(3'h1, 8'hf3);
         // result bytes are plain read-write between conversions
         wr(3'h2, 8'h5a);
         rd(3'h2, 8'h5a);
         wr(3'h3, 8'ha5);
         rd(3'h3, 8'ha5);
         wr(3'h7, 8'hff);
         rd(3'h7, 8'h00);
      end
   endtask
   // buffer and reserved channel codes and one ordinary code
   task t_chan;
      reg [19:0] codes;
      reg [4:0]  c;
      integer    i;
      begin
         codes = {5'h1f, 5'h1e, 5'h0e, 5'h05};
         for (i = 0; i < 4; i = i + 1) begin
            c = codes[i*5 +: 5];
            wr(3'h0, {1'b0, c, 2'b01});
            #1 chk(refbuf, c == 5'h1f);
            chk(conn, !(c == 5'h1e || c == 5'h0e));
         end
         wr(3'h0, 8'h00);
      end
   endtask
   // go without enable must not start
   task t_gate;
      begin
         wr(3'h0, 8'h02);
         repeat (3) @(posedge ref_clk);
         #1 chk(busy, 1'b0);
         rd(3'h0, 8'h00);
      end
   endtask
   // enable dropped mid-conversion: no result, no event, go cleared
   task t_abort;
      begin
         wr(3'h0, 8'h03);
         @(posedge ref_clk);
         #1 chk(busy, 1'b1);
         wr(3'h0, 8'h00);
         @(posedge ref_clk);
         #1 chk(busy, 1'b0);
         rd(3'h0, 8'h00);
         rd(3'h4, 8'h00);
         rd(3'h2, 8'h01);
         rd(3'h3, 8'hff);
      end
   endtask
   // full conversion per divider code, layout, interrupt mask, read clear
   task t_conv(input j, input m, input [2:0] dv, input [7:0] tc, input [9:0] s);
      integer k;
      begin
         wr(3'h5, {7'h00, m});
         wr(3'h1, {j, dv, 4'h0});
         wr(3'h0, 8'h01);
         conv_sample <= s;
         repeat (4) @(posedge ref_clk);
         wr(3'h0, 8'h03);
         @(posedge ref_clk);
         #1 chk(busy, 1'b1);
         k = 0;
         while (busy === 1'b1 && k < 300) begin
            @(posedge ref_clk);
            #1 k = k + 1;
         end
         chk(k, CT * tc);
         chk(irq, m);
         rd(3'h0, 8'h01);
         rd(3'h2, j ? {6'h00, s[9:8]} : s[9:2]);
         // left-justified bits 5:0 are padding only
         rd(3'h3, j ? s[7:0] : {s[1:0], 6'h00});
         rd(3'h4, 8'h01);
         chk(irq, 1'b0);
      end
   endtask
   // verdict and end of run
   task close_out;
      begin
         if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #20000;
      n_fail = n_fail + 1;
      close_out;
   end
   // main sequence
   initial begin
      n_fail = 0;
      n_compared = 0;
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      conv_sample = 10'h000;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs;
      t_chan;
      t_gate;
      t_conv(1'b0, 1'b1, 3'h0, 8'h02, 10'h2a5);
      t_conv(1'b1, 1'b0, 3'h5, 8'h10, 10'h35a);
      t_conv(1'b0, 1'b1, 3'h7, 8'h04, 10'h0c3);
      t_conv(1'b1, 1'b1, 3'h6, 8'h40, 10'h1ff);
      t_abort;
      close_out;
   end
endmodule // afc_adc_ctrl_tb
